// File: pkg/bdc_defs.svh
`ifndef BDC_DEFS_SVH
`define BDC_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define BDC_CTRL_OFS 8'hA3
`define BDC_LPF_OFS 8'hAB
`define BDC_UNLOCK_OFS 8'hC7

// ****************************************
// field positions
// ****************************************
`define BDC_EN_BIT 7
`define BDC_THR_HI 6
`define BDC_THR_LO 4
`define BDC_EVT_BIT 3
`define BDC_RSTEN_BIT 2
`define BDC_RFLAG_BIT 1
`define BDC_LOW_BIT 0
`define BDC_LP_HI 2
`define BDC_LP_LO 1
`define BDC_FLT_BIT 0

// ****************************************
// reset values and unlock keys
// ****************************************
`define BDC_CTRL_RST 8'h00
`define BDC_FLT_RST 1'b0
`define BDC_LP_RST 2'h0
`define BDC_KEY1 8'hAA
`define BDC_KEY2 8'h55

// ****************************************
// timing counts
// ****************************************
`define BDC_SETTLE_TICKS 2'h3
`define BDC_LOAD_CYCLES 3'h4
`define BDC_UNLOCK_CYCLES 3'h4
`define BDC_FLT_SYS_CLKS 6'h20
`define BDC_FLT_LSO_CLKS 6'h02
`define BDC_LP1_TICKS 9'h010
`define BDC_LP2_TICKS 9'h040
`define BDC_LP3_TICKS 9'h100

`endif

// File: pkg/bdc_pkg.sv
package bdc_pkg;

    // unlock sequence state, one-hot
    typedef enum logic [2:0]
    {
        BDC_UL_IDLE = 3'b001,
        BDC_UL_KEY1 = 3'b010,
        BDC_UL_OPEN = 3'b100
    } bdc_unlock_e;

    // low-power sampling selection
    typedef enum logic [1:0]
    {
        BDC_LP_CONT = 2'h0,
        BDC_LP_1 = 2'h1,
        BDC_LP_2 = 2'h2,
        BDC_LP_3 = 2'h3
    } bdc_lp_e;

endpackage

// File: rtl/bdc_filter.sv
`include "bdc_defs.svh"

// qualifies the comparator level: a change is taken only once it has held
// for the full count of system clocks or low-speed ticks
module bdc_filter
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // control
    input wire logic flt_on,
    input wire logic use_lso,
    input wire logic lso_tick,
    // level in and out
    input wire logic raw_in,
    output logic qual_out
);
    import bdc_pkg::*;

    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic qual_r;
    logic qual_nxt;
    logic step;
    logic [5:0] limit;

    // the counting clock is the system clock or the low-speed tick
    assign step = use_lso ? lso_tick : 1'b1;
    assign limit = use_lso ? `BDC_FLT_LSO_CLKS : `BDC_FLT_SYS_CLKS; // RULE_11 RULE_12

    // any return to the held level restarts the count, so glitches shorter
    // than the window never get through
    always_comb
    begin
        cnt_nxt = cnt_r;
        qual_nxt = qual_r;
        if (!flt_on)
        begin
            cnt_nxt = 6'h00;
            qual_nxt = raw_in;
        end
        else if (raw_in == qual_r)
        begin
            cnt_nxt = 6'h00;
        end
        else if (step)
        begin
            if (cnt_r + 6'h01 >= limit)
            begin
                cnt_nxt = 6'h00;
                qual_nxt = raw_in;
            end
            else
            begin
                cnt_nxt = cnt_r + 6'h01;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= 6'h00;
            qual_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            qual_r <= qual_nxt;
        end
    end

    assign qual_out = qual_r;

endmodule // bdc_filter

// File: rtl/bdc_top.sv
// Functional notes
// RULE_01: after enable rises, ignore the comparator for two to three slow-oscillator periods.
// RULE_02: threshold field bits 6:4 codes 11/10/01/00 map 2.2/2.7/3.7/4.4V, driven out.
// RULE_03: event flag bit 3 set on any threshold crossing, falling or rising.
// RULE_04: interrupt request while flag set and both interrupt enables are one.
// RULE_05: reset-enable bit 2 one issues system reset on supply low; zero none.
// RULE_06: reset flag bit 1 set by hardware on brown-out reset; software clears.
// RULE_07: status bit 0 reads one only when enabled and supply below threshold.
// RULE_08: every reset loads enable, threshold and reset-enable from configuration bits.
// RULE_09: event flag resets to one only for enable=1, reset-enable=0, supply low.
// RULE_10: low-power field selects continuous or 1.6/6.4/25.6 ms periodic sensing.
// RULE_11: filter on, continuous, fast system clock: qualify over 32 system clocks.
// RULE_12: other filtered setups qualify over 2 slow-oscillator clocks.
// RULE_13: in power-down always filter over 2 slow-oscillator clocks.
// RULE_14: filter bit 0 enables the filter; zero after power-on reset.
// RULE_15: filter off, low-power 1/2/3: shortest pulse 16/64/256 slow periods.
// RULE_16: filter on, low-power 1/2/3: shortest pulse 18/66/258 slow periods.
// RULE_17: both control registers accept writes only through timed-access unlock.
// RULE_18: a cleared flag stays clear until a new crossing.
// RULE_19: reset flag survives every reset except power-on.
// RULE_20: comparator output passes a two-stage synchroniser before use.
// RULE_21: two unlock keys in order open a short window; other writes ignored.
//
// Our own choice: strobed register access.
`include "bdc_defs.svh"

module bdc_top
(
    // clock and resets
    input wire logic clock,
    input wire logic rst_n,
    input wire logic por_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // configuration and system state
    input wire logic [7:0] nonvolatile_config_byte,
    input wire logic cpu_power_down,
    input wire logic sysclk_is_low_speed_osc,
    input wire logic brownout_irq_enable,
    input wire logic global_irq_enable,
    // slow oscillator and analog comparator
    input wire logic low_speed_osc,
    input wire logic cmp_below_async,
    output logic [1:0] threshold_code,
    output logic cmp_power_on,
    // requests to the system
    output logic irq_req,
    output logic sys_reset_req
);
    import bdc_pkg::*;

    // ****************************************
    // helper functions
    // ****************************************

    // sensing period in slow ticks for each low-power selection
    function automatic logic [8:0] lp_period(input logic [1:0] sel);
        case (sel)
            BDC_LP_1: lp_period = `BDC_LP1_TICKS;
            BDC_LP_2: lp_period = `BDC_LP2_TICKS;
            BDC_LP_3: lp_period = `BDC_LP3_TICKS;
            default: lp_period = 9'h001;
        endcase
    endfunction

    // ****************************************
    // declarations
    // ****************************************
    logic [1:0] lso_sync_r;
    logic lso_prev_r;
    logic lso_tick;
    logic [1:0] cmp_sync_r;
    logic cmp_sync;

    logic [2:0] load_cnt_r;
    logic load_ctrl;
    logic load_evt;
    logic loading;

    logic detect_enable_r;
    logic [2:0] threshold_select_r;
    logic event_flag_r;
    logic event_flag_nxt;
    logic reset_enable_bit_r;
    logic brownout_reset_flag_r;
    logic brownout_reset_flag_nxt;
    logic [1:0] low_power_sense_select_r;
    logic noise_filter_enable_r;

    bdc_unlock_e ul_state_r;
    bdc_unlock_e ul_state_nxt;
    logic [2:0] ul_cnt_r;
    logic [2:0] ul_cnt_nxt;
    logic ul_open;

    logic en_prev_r;
    logic [1:0] settle_cnt_r;
    logic settled;

    logic [8:0] lp_cnt_r;
    logic [8:0] lp_last;
    logic lp_mode;
    logic lp_slot;
    logic sampled_r;
    logic raw_level;
    logic flt_on;
    logic flt_use_lso;
    logic filtered;

    logic supply_low_status;
    logic low_prev_r;
    logic crossing;

    logic hit_ctrl;
    logic hit_lpf;
    logic hit_unlock;
    logic wr_ctrl;
    logic wr_lpf;
    logic [7:0] ctrl_view;
    logic [7:0] lpf_view;
    logic [7:0] rd_mux;

    // ****************************************
    // synchronisers
    // ****************************************

    // first stages feed only second stages; edge detect uses the second
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lso_sync_r <= 2'h0;
            lso_prev_r <= 1'b0;
            cmp_sync_r <= 2'h0;
        end
        else
        begin
            lso_sync_r <= {lso_sync_r[0], low_speed_osc};
            lso_prev_r <= lso_sync_r[1];
            cmp_sync_r <= {cmp_sync_r[0], cmp_below_async}; // RULE_20
        end
    end

    assign lso_tick = lso_sync_r[1] & ~lso_prev_r;
    assign cmp_sync = cmp_sync_r[1]; // RULE_20

    // ****************************************
    // configuration load after reset
    // ****************************************

    // the last load cycle waits for the comparator synchroniser to settle
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            load_cnt_r <= `BDC_LOAD_CYCLES;
        end
        else if (load_cnt_r != 3'h0)
        begin
            load_cnt_r <= load_cnt_r - 3'h1;
        end
    end

    // the comparator powers up only once the enable is loaded, so the flag
    // load waits two more edges for a powered level through the synchroniser
    assign loading = (load_cnt_r != 3'h0);
    assign load_ctrl = (load_cnt_r == `BDC_LOAD_CYCLES);
    assign load_evt = (load_cnt_r == 3'h1);

    // ****************************************
    // register decode
    // ****************************************
    assign hit_ctrl = (reg_addr == `BDC_CTRL_OFS);
    assign hit_lpf = (reg_addr == `BDC_LPF_OFS);
    assign hit_unlock = (reg_addr == `BDC_UNLOCK_OFS);
    assign wr_ctrl = reg_wr & hit_ctrl & ul_open & ~loading; // RULE_17
    assign wr_lpf = reg_wr & hit_lpf & ul_open; // RULE_17

    // ****************************************
    // timed-access unlock
    // ****************************************

    // any write to a protected register spends the window, so each write
    // needs its own unlock pair
    assign ul_open = (ul_state_r == BDC_UL_OPEN); // RULE_21

    always_comb
    begin
        ul_state_nxt = ul_state_r;
        ul_cnt_nxt = ul_cnt_r;
        case (ul_state_r)
            BDC_UL_IDLE:
            begin
                if (reg_wr & hit_unlock & (reg_wdata == `BDC_KEY1))
                begin
                    ul_state_nxt = BDC_UL_KEY1;
                end
            end
            BDC_UL_KEY1:
            begin
                if (reg_wr)
                begin
                    if (hit_unlock & (reg_wdata == `BDC_KEY2)) // RULE_21
                    begin
                        ul_state_nxt = BDC_UL_OPEN;
                        ul_cnt_nxt = `BDC_UNLOCK_CYCLES;
                    end
                    else
                    begin
                        ul_state_nxt = BDC_UL_IDLE;
                    end
                end
            end
            BDC_UL_OPEN:
            begin
                ul_cnt_nxt = ul_cnt_r - 3'h1;
                if (reg_wr | (ul_cnt_r == 3'h1)) // RULE_21
                begin
                    ul_state_nxt = BDC_UL_IDLE;
                end
            end
            default:
            begin
                ul_state_nxt = BDC_UL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ul_state_r <= BDC_UL_IDLE;
            ul_cnt_r <= 3'h0;
        end
        else
        begin
            ul_state_r <= ul_state_nxt;
            ul_cnt_r <= ul_cnt_nxt;
        end
    end

    // ****************************************
    // control fields
    // ****************************************

    // system-reset domain: enable, threshold and reset-enable reloaded from configuration after every reset, low-power select cleared
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            detect_enable_r <= 1'b0;
            threshold_select_r <= 3'h0;
            reset_enable_bit_r <= 1'b0;
            low_power_sense_select_r <= `BDC_LP_RST;
        end
        else if (load_ctrl)
        begin
            detect_enable_r <= nonvolatile_config_byte[`BDC_EN_BIT]; // RULE_08
            threshold_select_r <= nonvolatile_config_byte[`BDC_THR_HI:`BDC_THR_LO]; // RULE_08
            reset_enable_bit_r <= nonvolatile_config_byte[`BDC_RSTEN_BIT]; // RULE_08
        end
        else
        begin
            if (wr_ctrl)
            begin
                detect_enable_r <= reg_wdata[`BDC_EN_BIT];
                threshold_select_r <= reg_wdata[`BDC_THR_HI:`BDC_THR_LO];
                reset_enable_bit_r <= reg_wdata[`BDC_RSTEN_BIT];
            end
            if (wr_lpf)
            begin
                low_power_sense_select_r <= reg_wdata[`BDC_LP_HI:`BDC_LP_LO]; // RULE_10
            end
        end
    end

    // event flag: hardware set wins over a software clear in the same cycle
    always_comb
    begin
        event_flag_nxt = event_flag_r;
        if (load_evt)
        begin
            event_flag_nxt = nonvolatile_config_byte[`BDC_EN_BIT]
                & ~nonvolatile_config_byte[`BDC_RSTEN_BIT] & cmp_sync; // RULE_09
        end
        else if (crossing)
        begin
            event_flag_nxt = 1'b1; // RULE_03
        end
        else if (wr_ctrl)
        begin
            event_flag_nxt = reg_wdata[`BDC_EVT_BIT];
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            event_flag_r <= 1'b0; // RULE_09
        end
        else
        begin
            event_flag_r <= event_flag_nxt;
        end
    end

    // power-on domain: the cause flag and filter bit survive other resets
    always_comb
    begin
        brownout_reset_flag_nxt = brownout_reset_flag_r;
        if (sys_reset_req)
        begin
            brownout_reset_flag_nxt = 1'b1; // RULE_06
        end
        else if (wr_ctrl)
        begin
            brownout_reset_flag_nxt = reg_wdata[`BDC_RFLAG_BIT];
        end
    end

    always_ff @(posedge clock or negedge por_n)
    begin
        if (!por_n)
        begin
            brownout_reset_flag_r <= 1'b0; // RULE_19
            noise_filter_enable_r <= `BDC_FLT_RST; // RULE_14
        end
        else
        begin
            brownout_reset_flag_r <= brownout_reset_flag_nxt; // RULE_19
            if (wr_lpf)
            begin
                noise_filter_enable_r <= reg_wdata[`BDC_FLT_BIT]; // RULE_14
            end
        end
    end

    // ****************************************
    // enable settling
    // ****************************************

    // counting three slow ticks from an unaligned start gives two to three
    // periods of blanking
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            en_prev_r <= 1'b0;
            settle_cnt_r <= 2'h0;
        end
        else
        begin
            en_prev_r <= detect_enable_r;
            if (detect_enable_r & ~en_prev_r)
            begin
                settle_cnt_r <= `BDC_SETTLE_TICKS; // RULE_01
            end
            else if (lso_tick & (settle_cnt_r != 2'h0))
            begin
                settle_cnt_r <= settle_cnt_r - 2'h1; // RULE_01
            end
        end
    end

    assign settled = (settle_cnt_r == 2'h0) & ~(detect_enable_r & ~en_prev_r);

    // ****************************************
    // low-power periodic sensing
    // ****************************************
    assign lp_mode = (low_power_sense_select_r != BDC_LP_CONT);
    assign lp_last = lp_period(low_power_sense_select_r) - 9'h001;
    assign lp_slot = (lp_cnt_r == lp_last);

    // the comparator is powered for one slow tick per period and its level
    // is latched at the end of that tick
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lp_cnt_r <= 9'h000;
            sampled_r <= 1'b0;
        end
        else if (!lp_mode | !detect_enable_r)
        begin
            lp_cnt_r <= 9'h000;
            sampled_r <= 1'b0;
        end
        else if (lso_tick)
        begin
            lp_cnt_r <= lp_slot ? 9'h000 : lp_cnt_r + 9'h001; // RULE_10
            if (lp_slot)
            begin
                sampled_r <= cmp_sync; // RULE_15
            end
        end
    end

    assign cmp_power_on = detect_enable_r & (~lp_mode | lp_slot); // RULE_10
    assign raw_level = lp_mode ? sampled_r : cmp_sync;

    // ****************************************
    // noise filter
    // ****************************************
    assign flt_on = noise_filter_enable_r | cpu_power_down; // RULE_13
    assign flt_use_lso = cpu_power_down | lp_mode | sysclk_is_low_speed_osc; // RULE_12

    // RULE_11 RULE_16 the filter counts 32 system clocks or 2 slow ticks
    bdc_filter u_filter
    (
        .clock(clock),
        .rst_n(rst_n),
        .flt_on(flt_on),
        .use_lso(flt_use_lso),
        .lso_tick(lso_tick),
        .raw_in(raw_level),
        .qual_out(filtered)
    );

    // ****************************************
    // status, events and requests
    // ****************************************
    assign supply_low_status = detect_enable_r & settled & filtered; // RULE_07
    assign crossing = ~loading & (supply_low_status != low_prev_r); // RULE_03 RULE_18

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_prev_r <= 1'b0;
        end
        else
        begin
            low_prev_r <= supply_low_status;
        end
    end

    assign irq_req = event_flag_r & brownout_irq_enable & global_irq_enable; // RULE_04
    assign sys_reset_req = reset_enable_bit_r & supply_low_status; // RULE_05
    assign threshold_code = threshold_select_r[1:0]; // RULE_02

    // ****************************************
    // read path
    // ****************************************
    assign ctrl_view = {detect_enable_r, threshold_select_r, event_flag_r,
        reset_enable_bit_r, brownout_reset_flag_r, supply_low_status};
    assign lpf_view = {5'h00, low_power_sense_select_r, noise_filter_enable_r};
    assign rd_mux = hit_ctrl ? ctrl_view : (hit_lpf ? lpf_view : 8'h00);

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 8'h00;
        end
        else
        begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

endmodule // bdc_top

// File: sim/bdc_top_chk.sv
// ****************************************
// port checker for the brown-out block
// ****************************************
module bdc_top_chk
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // system side
    input wire logic [7:0] nonvolatile_config_byte,
    input wire logic brownout_irq_enable,
    input wire logic global_irq_enable,
    input wire logic [1:0] threshold_code,
    input wire logic cmp_power_on,
    input wire logic irq_req,
    input wire logic sys_reset_req
);
    logic [1:0] rd_sel_r;

    // which register the last read aimed at; read data lags one cycle
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rd_sel_r <= 2'h0;
        else
            rd_sel_r <= {reg_rd && reg_addr == 8'hAB, reg_rd && reg_addr == 8'hA3};
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_IRQ_GATE: assert property (irq_req |-> brownout_irq_enable && global_irq_enable)
        else $error("interrupt request without both enables");
    AST_IRQ_FLAG: assert property (rd_sel_r[0] |-> $past(irq_req) == (reg_rdata[3]
        && $past(brownout_irq_enable) && $past(global_irq_enable)))
        else $error("interrupt request disagrees with event flag");
    AST_RST_REQ: assert property (rd_sel_r[0] |-> $past(sys_reset_req) == (reg_rdata[2]
        && reg_rdata[0])) else $error("system reset request disagrees with register");
    AST_THR_OUT: assert property (rd_sel_r[0] |-> $past(threshold_code) == reg_rdata[5:4])
        else $error("threshold code differs from register field");
    AST_OFF_STATUS: assert property (rd_sel_r[0] && !reg_rdata[7] |-> !reg_rdata[0])
        else $error("status high while detection is off");
    AST_OFF_POWER: assert property (rd_sel_r[0] && !reg_rdata[7] |-> !$past(cmp_power_on))
        else $error("comparator powered while detection is off");
    AST_LPF_RSVD: assert property (rd_sel_r[1] |-> reg_rdata[7:3] == 5'h00)
        else $error("reserved bits of low-power register not zero");
    AST_CFG_LOAD: assert property ($rose(rst_n) |=>
        threshold_code == nonvolatile_config_byte[5:4])
        else $error("threshold not loaded from configuration");
endmodule // bdc_top_chk

bind bdc_top bdc_top_chk u_bdc_top_chk (.clock, .rst_n, .reg_addr, .reg_rd, .reg_rdata,
    .nonvolatile_config_byte, .brownout_irq_enable, .global_irq_enable, .threshold_code,
    .cmp_power_on, .irq_req, .sys_reset_req);

// File: sim/bdc_supply_model.sv
// ****************************************
// supply comparator model
// ****************************************
module bdc_supply_model
(
    // supply level in millivolts, set by the bench
    input wire logic [15:0] supply_mv,
    // comparator side of the block
    input wire logic [1:0] threshold_code,
    input wire logic cmp_power_on,
    output logic cmp_below_async
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] trip_mv;
    logic last_r = 1'b1;

    // trip point for each threshold code
    assign trip_mv = threshold_code == 2'h3 ? 16'h0898 : threshold_code == 2'h2 ? 16'h0A8C :
        threshold_code == 2'h1 ? 16'h0E74 : 16'h1130;

    // unpowered comparator gives no valid answer, so show the inverse of the last one
    always @(cmp_power_on or supply_mv or trip_mv)
        if (cmp_power_on)
            last_r = supply_mv < trip_mv;
    assign cmp_below_async = cmp_power_on ? last_r : !last_r;
endmodule // bdc_supply_model

// File: sim/bdc_top_tb_top.sv
// ****************************************
// register-level bench for the brown-out block
// ****************************************
module bdc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic por_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] cfg = 8'hA0;
    logic pd = 1'b0;
    logic slow_sys = 1'b0;
    logic irq_en = 1'b0;
    logic ea = 1'b0;
    logic lso = 1'b0;
    logic cmp_below;
    logic [1:0] thr;
    logic cmp_pwr;
    logic irq_req;
    logic sys_reset_req;
    logic [15:0] supply_mv = 16'h1388;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;
    int m;

    always #5 clock = ~clock;
    // slow oscillator, 20 system clocks a period
    always #100 lso = ~lso;

    bdc_top u_bdc_top (.clock(clock), .rst_n(rst_n), .por_n(por_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .nonvolatile_config_byte(cfg), .cpu_power_down(pd), .sysclk_is_low_speed_osc(slow_sys),
        .brownout_irq_enable(irq_en), .global_irq_enable(ea), .low_speed_osc(lso),
        .cmp_below_async(cmp_below), .threshold_code(thr), .cmp_power_on(cmp_pwr),
        .irq_req(irq_req), .sys_reset_req(sys_reset_req));
    bdc_supply_model u_bdc_supply_model (.supply_mv(supply_mv), .threshold_code(thr),
        .cmp_power_on(cmp_pwr), .cmp_below_async(cmp_below));

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // the trailing delay lets the write land before anything looks at it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(nm, e, reg_rdata);
    endtask

    // every protected write needs its own unlock pair
    task automatic ta(input logic [7:0] a, input logic [7:0] d);
        wr(8'hC7, 8'hAA);
        wr(8'hC7, 8'h55);
        wr(a, d);
    endtask

    task automatic rst(input logic por);
        @(posedge clock);
        rst_n <= 1'b0;
        por_n <= !por;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        repeat (4) @(posedge clock);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // hang guard, well above the length of the sequence
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_total++;
            complete_run();
        end
    end

    initial
    begin
        rst(1'b1);
        rc(8'hA3, 8'hA0, "ctrl after por");
        rc(8'hAB, 8'h00, "lpf after por");
        rc(8'h10, 8'h00, "unmapped");
        $display("reset test done");
        wr(8'hA3, 8'h00);
        wr(8'hC7, 8'hAA);
        wr(8'hC7, 8'h11);
        wr(8'hA3, 8'h00);
        rc(8'hA3, 8'hA0, "ctrl locked");
        for (n = 0; n < 4; n++)
        begin
            ta(8'hA3, 8'h80 | 8'(n << 4));
            chk("thr code", 8'(n), {6'h00, thr});
        end
        wr(8'hA3, 8'hA0);
        rc(8'hA3, 8'hB0, "window used");
        ta(8'hA3, 8'hA0);
        $display("access test done");
        supply_mv <= 16'h09C4;
        repeat (20) @(posedge clock);
        rc(8'hA3, 8'hA9, "drop");
        irq_en <= 1'b1;
        ea <= 1'b1;
        @(posedge clock);
        #1 chk("irq on", 8'h01, {7'h00, irq_req});
        ta(8'hA3, 8'hA0);
        repeat (20) @(posedge clock);
        rc(8'hA3, 8'hA1, "cleared stays");
        chk("irq off", 8'h00, {7'h00, irq_req});
        supply_mv <= 16'h1388;
        repeat (20) @(posedge clock);
        rc(8'hA3, 8'hA8, "rise");
        ea <= 1'b0;
        ta(8'hA3, 8'hA0);
        $display("event test done");
        ta(8'hAB, 8'h01);
        supply_mv <= 16'h09C4;
        repeat (20) @(posedge clock);
        supply_mv <= 16'h1388;
        repeat (60) @(posedge clock);
        rc(8'hA3, 8'hA0, "short pulse");
        supply_mv <= 16'h09C4;
        repeat (28) @(posedge clock);
        rc(8'hA3, 8'hA0, "held 30");
        repeat (30) @(posedge clock);
        rc(8'hA3, 8'hA9, "held long");
        supply_mv <= 16'h1388;
        repeat (60) @(posedge clock);
        ta(8'hA3, 8'hA4);
        $display("filter test done");
        supply_mv <= 16'h09C4;
        n = 0;
        while (sys_reset_req !== 1'b1 && n < 200)
        begin
            @(posedge clock);
            n++;
        end
        chk("reset req", 8'h01, {7'h00, sys_reset_req});
        supply_mv <= 16'h1388;
        rst(1'b0);
        rc(8'hA3, 8'hA2, "reset flag kept");
        rc(8'hAB, 8'h01, "filter kept");
        cfg <= 8'h20;
        supply_mv <= 16'h09C4;
        rst(1'b1);
        rc(8'hA3, 8'h20, "disabled low");
        rc(8'hAB, 8'h00, "filter por");
        ta(8'hA3, 8'hA0);
        rc(8'hA3, 8'hA0, "blanked");
        repeat (100) @(posedge clock);
        rc(8'hA3, 8'hA9, "after blank");
        chk("no reset", 8'h00, {7'h00, sys_reset_req});
        $display("reset test done");
        supply_mv <= 16'h1388;
        for (m = 0; m < 4; m++)
        begin
            ta(8'hAB, 8'(m << 1));
            n = 0;
            repeat (6000) @(posedge clock) n += int'(cmp_pwr === 1'b1);
            chk("power full", m == 0 ? 8'h01 : 8'h00, {7'h00, n == 6000});
            chk("power slots", 8'h01, {7'h00, n > 0});
        end
        $display("low power test done");
        ta(8'hAB, 8'h00);
        pd <= 1'b1;
        supply_mv <= 16'h09C4;
        repeat (12) @(posedge clock);
        rc(8'hA3, 8'hA8, "pd filtered");
        repeat (60) @(posedge clock);
        rc(8'hA3, 8'hA9, "pd held");
        $display("power-down test done");
        complete_run();
    end
endmodule // bdc_top_tb_top
